//--- src/mode_bank_pkg.sv
// Package: addresses, field layouts, defaults and carrier types for the mode register bank
package mode_bank_pkg;
   localparam int ADDR_W = 6;
   localparam logic [5:0] ADDR_REV_FIRST = 6'h06;
   localparam logic [5:0] ADDR_REV_SECOND = 6'h07;
   localparam logic [5:0] ADDR_GEOMETRY = 6'h08;
   localparam logic [5:0] ADDR_VENDOR_TEST = 6'h09;
   localparam logic [5:0] ADDR_CAL_RESET = 6'h0A;
   localparam logic [5:0] ADDR_TERMINATION = 6'h0B;
   localparam logic [7:0] VENDOR_TEST_LEGAL = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Field positions
   localparam int CAL_RESET_BIT = 0;
   localparam int DQ_TERM_LSB = 0;
   localparam int CA_TERM_LSB = 4;
   localparam int TERM_W = 3;
   localparam int TYPE_LSB = 0;
   localparam int DENSITY_LSB = 2;
   localparam int WIDTH_LSB = 6;
   // Encodings
   localparam logic [2:0] TERM_OFF = 3'h0;
   localparam logic [2:0] TERM_RESERVED = 3'h7;
   localparam logic [1:0] TYPE_S16 = 2'h0;
   localparam logic [1:0] TYPE_LOW_VDDQ = 2'h1;
   localparam logic [3:0] DENSITY_4GB = 4'h0;
   localparam logic [3:0] DENSITY_16GB = 4'h4;
   localparam logic [3:0] DENSITY_32GB = 4'h6;
   localparam logic [3:0] DENSITY_2GB = 4'hC;
   localparam logic [1:0] WIDTH_X16 = 2'h0;
   localparam logic [1:0] WIDTH_X8 = 2'h1;
   localparam int NUM_SET_POINTS = 2;

   typedef struct packed {
      logic write_en;
      logic read_en;
      logic [5:0] addr;
      logic [7:0] data;
   } mode_cmd_t;

   typedef struct packed {
      logic [2:0] cmd_addr_receiver_termination;
      logic [2:0] data_receiver_termination;
   } term_setting_t;

   typedef struct packed {
      logic [1:0] io_width;
      logic [3:0] density;
      logic [1:0] mem_type;
   } geometry_t;
endpackage : mode_bank_pkg

//--- src/term_set_store.sv
// Two-set-point storage for the termination settings
`timescale 1ns/1ps
module term_set_store
   import mode_bank_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic wr_sel,
   input mode_bank_pkg::term_setting_t wr_data,
   input wire logic op_sel,
   output mode_bank_pkg::term_setting_t active
);
   term_setting_t store [NUM_SET_POINTS];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         store[0] <= '{TERM_OFF, TERM_OFF};
         store[1] <= '{TERM_OFF, TERM_OFF};
      end
      else if (wr_en)
      begin
         store[wr_sel] <= wr_data;
      end
   end

   // Registered read keeps the termination control glitch free
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         active <= '{TERM_OFF, TERM_OFF};
      else
         active <= store[op_sel];
   end
endmodule : term_set_store

//--- src/mode_register_bank_mid.sv
// Mode register bank for addresses 06h..0Bh: identifiers, geometry, calibration reset, termination
`timescale 1ns/1ps
module mode_register_bank_mid
   import mode_bank_pkg::*;
#(
   parameter logic [7:0] REV_FIRST = 8'h5A, // Arbitrary value
   parameter logic [7:0] REV_SECOND = 8'hA5, // Arbitrary value
   parameter logic [1:0] GEOM_TYPE = TYPE_LOW_VDDQ,
   parameter logic [3:0] GEOM_DENSITY = DENSITY_16GB,
   parameter logic [1:0] GEOM_WIDTH = WIDTH_X16
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input mode_bank_pkg::mode_cmd_t CMD,
   input wire logic WRITE_SET_POINT_SELECT,
   input wire logic OPERATING_SET_POINT_SELECT,
   input wire logic CAL_PIN_HAS_RESISTOR,
   input wire logic ZQ_CAL_CMD,
   output logic [7:0] READ_DATA,
   output logic READ_VALID,
   output logic [2:0] DATA_RECEIVER_TERMINATION,
   output logic [2:0] CMD_ADDR_RECEIVER_TERMINATION,
   output logic CALIBRATION_DEFAULT_RESTORE,
   output logic ZQ_CAL_START,
   output logic VENDOR_TEST_VIOLATION
);
   import mode_bank_pkg::*;

   geometry_t geometry;
   term_setting_t term_wr;
   term_setting_t term_active;
   logic term_we;
   logic pin_s1;
   logic pin_s2;
   logic cal_restore_pending;

   function automatic logic hit(input mode_cmd_t c, input logic [5:0] a, input logic wr);
      hit = (wr ? c.write_en : c.read_en) && (c.addr == a);
   endfunction : hit

   // Strap pin is asynchronous to CLK
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end
      else
      begin
         pin_s1 <= CAL_PIN_HAS_RESISTOR;
         pin_s2 <= pin_s1;
      end
   end

   always_comb
   begin
      geometry.mem_type = GEOM_TYPE;
      geometry.density = GEOM_DENSITY;
      geometry.io_width = GEOM_WIDTH;
   end

   // Reserved bits 3 and 7 are dropped here
   always_comb
   begin
      term_wr.data_receiver_termination = CMD.data[DQ_TERM_LSB +: TERM_W];
      term_wr.cmd_addr_receiver_termination = CMD.data[CA_TERM_LSB +: TERM_W];
      term_we = hit(CMD, ADDR_TERMINATION, 1'b1);
   end

   term_set_store u_store (
      .clk(CLK),
      .rst_n(RST_N),
      .wr_en(term_we),
      .wr_sel(WRITE_SET_POINT_SELECT),
      .wr_data(term_wr),
      .op_sel(OPERATING_SET_POINT_SELECT),
      .active(term_active)
   );

   // Reserved encoding is treated as off so the receivers never see an undefined leg
   always_comb
   begin
      DATA_RECEIVER_TERMINATION = (term_active.data_receiver_termination == TERM_RESERVED) ? TERM_OFF
         : term_active.data_receiver_termination;
      CMD_ADDR_RECEIVER_TERMINATION = (term_active.cmd_addr_receiver_termination == TERM_RESERVED) ? TERM_OFF
         : term_active.cmd_addr_receiver_termination;
   end

   // Self-clearing pulse; the bit itself reads nothing since the register is write-only
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         cal_restore_pending <= 1'b0;
      else
         cal_restore_pending <= hit(CMD, ADDR_CAL_RESET, 1'b1) && CMD.data[CAL_RESET_BIT];
   end
   assign CALIBRATION_DEFAULT_RESTORE = cal_restore_pending;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         ZQ_CAL_START <= 1'b0;
      else
         ZQ_CAL_START <= ZQ_CAL_CMD && pin_s2;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         VENDOR_TEST_VIOLATION <= 1'b0;
      else if (hit(CMD, ADDR_VENDOR_TEST, 1'b1) && CMD.data != VENDOR_TEST_LEGAL)
         VENDOR_TEST_VIOLATION <= 1'b1;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         READ_DATA <= BYTE_ZERO;
         READ_VALID <= 1'b0;
      end
      else
      begin
         READ_VALID <= CMD.read_en;
         if (!CMD.read_en)
            READ_DATA <= BYTE_ZERO;
         else
            case (CMD.addr)
               ADDR_REV_FIRST: READ_DATA <= REV_FIRST;
               ADDR_REV_SECOND: READ_DATA <= REV_SECOND;
               ADDR_GEOMETRY: READ_DATA <= geometry;
               default: READ_DATA <= BYTE_ZERO;
            endcase
      end
   end

   // Identifier and geometry reads
   a_rev_first_read: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_REV_FIRST, 1'b0) |=> READ_VALID && READ_DATA == REV_FIRST) else $error("rev first wrong");

   a_rev_second_read: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_REV_SECOND, 1'b0) |=> READ_DATA == REV_SECOND) else $error("rev second wrong");

   a_geom_type_field: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_GEOMETRY, 1'b0) |=> READ_DATA[1:0] == GEOM_TYPE) else $error("type wrong");

   a_geom_density_field: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_GEOMETRY, 1'b0) |=> READ_DATA[5:2] == GEOM_DENSITY) else $error("density wrong");

   a_geom_width_field: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_GEOMETRY, 1'b0) |=> READ_DATA[7:6] == GEOM_WIDTH) else $error("width wrong");

   a_geom_whole_byte: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_GEOMETRY, 1'b0) |=> READ_DATA == {GEOM_WIDTH, GEOM_DENSITY, GEOM_TYPE})
      else $error("geometry byte wrong");

   // Read strobe timing and zero fill
   a_read_valid_follow: assert property (@(posedge CLK) disable iff (!RST_N)
      CMD.read_en |=> READ_VALID) else $error("read valid missing");

   a_read_valid_idle: assert property (@(posedge CLK) disable iff (!RST_N)
      !CMD.read_en |=> !READ_VALID) else $error("read valid without read");

   a_read_idle_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      !CMD.read_en |=> READ_DATA == BYTE_ZERO) else $error("read data not zero when idle");

   a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      (CMD.read_en && CMD.addr > ADDR_GEOMETRY) |=> READ_DATA == BYTE_ZERO) else $error("reserved not zero");

   a_low_addr_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      (CMD.read_en && CMD.addr < ADDR_REV_FIRST) |=> READ_DATA == BYTE_ZERO) else $error("low address not zero");

   a_vendor_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_VENDOR_TEST, 1'b0) |=> READ_DATA == BYTE_ZERO) else $error("vendor read not zero");

   a_cal_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_CAL_RESET, 1'b0) |=> READ_DATA == BYTE_ZERO) else $error("cal reset read not zero");

   a_term_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      hit(CMD, ADDR_TERMINATION, 1'b0) |=> READ_DATA == BYTE_ZERO) else $error("termination read not zero");

   // Calibration restore and calibration start
   a_cal_restore_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
      (hit(CMD, ADDR_CAL_RESET, 1'b1) && CMD.data[CAL_RESET_BIT]) |=> CALIBRATION_DEFAULT_RESTORE
      ##1 (!CALIBRATION_DEFAULT_RESTORE || hit($past(CMD), ADDR_CAL_RESET, 1'b1)))
      else $error("restore pulse wrong");

   a_restore_needs_write: assert property (@(posedge CLK) disable iff (!RST_N)
      !hit(CMD, ADDR_CAL_RESET, 1'b1) |=> !CALIBRATION_DEFAULT_RESTORE) else $error("restore without write");

   a_restore_zero_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
      (hit(CMD, ADDR_CAL_RESET, 1'b1) && !CMD.data[CAL_RESET_BIT]) |=> !CALIBRATION_DEFAULT_RESTORE)
      else $error("reserved bits caused restore");

   a_zq_ignored_grounded: assert property (@(posedge CLK) disable iff (!RST_N)
      (!pin_s2 && !$past(pin_s2)) |-> !ZQ_CAL_START) else $error("zq not ignored");

   a_zq_needs_cmd: assert property (@(posedge CLK) disable iff (!RST_N)
      !ZQ_CAL_CMD |=> !ZQ_CAL_START) else $error("zq start without command");

   a_zq_with_resistor: assert property (@(posedge CLK) disable iff (!RST_N)
      (ZQ_CAL_CMD && pin_s2) |=> ZQ_CAL_START) else $error("zq command dropped");

   a_strap_two_stage: assert property (@(posedge CLK) disable iff (!RST_N)
      pin_s2 == $past(pin_s1)) else $error("strap synchroniser skipped");

   // Termination copies
   a_term_write_select: assert property (@(posedge CLK) disable iff (!RST_N)
      (term_we && WRITE_SET_POINT_SELECT == OPERATING_SET_POINT_SELECT
      && CMD.data[DQ_TERM_LSB +: TERM_W] != TERM_RESERVED)
      ##1 (!term_we && $stable(OPERATING_SET_POINT_SELECT))
      |=> DATA_RECEIVER_TERMINATION == $past(CMD.data[DQ_TERM_LSB +: TERM_W], 2))
      else $error("dq term not applied");

   a_ca_write_select: assert property (@(posedge CLK) disable iff (!RST_N)
      (term_we && WRITE_SET_POINT_SELECT == OPERATING_SET_POINT_SELECT
      && CMD.data[CA_TERM_LSB +: TERM_W] != TERM_RESERVED)
      ##1 (!term_we && $stable(OPERATING_SET_POINT_SELECT))
      |=> CMD_ADDR_RECEIVER_TERMINATION == $past(CMD.data[CA_TERM_LSB +: TERM_W], 2))
      else $error("ca term not applied");

   a_term_inactive_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
      (term_we && WRITE_SET_POINT_SELECT != OPERATING_SET_POINT_SELECT && $stable(OPERATING_SET_POINT_SELECT))
      ##1 $stable(OPERATING_SET_POINT_SELECT) |=> $stable(CMD_ADDR_RECEIVER_TERMINATION))
      else $error("inactive copy disturbed");

   a_dq_inactive_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
      (term_we && WRITE_SET_POINT_SELECT != OPERATING_SET_POINT_SELECT && $stable(OPERATING_SET_POINT_SELECT))
      ##1 $stable(OPERATING_SET_POINT_SELECT) |=> $stable(DATA_RECEIVER_TERMINATION))
      else $error("inactive dq copy disturbed");

   a_dq_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (!term_we ##1 $stable(OPERATING_SET_POINT_SELECT)) |=> $stable(DATA_RECEIVER_TERMINATION))
      else $error("dq term moved without cause");

   a_ca_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (!term_we ##1 $stable(OPERATING_SET_POINT_SELECT)) |=> $stable(CMD_ADDR_RECEIVER_TERMINATION))
      else $error("ca term moved without cause");

   a_dq_never_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
      DATA_RECEIVER_TERMINATION != TERM_RESERVED) else $error("dq reserved code driven");

   a_ca_never_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
      CMD_ADDR_RECEIVER_TERMINATION != TERM_RESERVED) else $error("ca reserved code driven");

   // Vendor test register misuse flag
   a_vendor_flag_set: assert property (@(posedge CLK) disable iff (!RST_N)
      (hit(CMD, ADDR_VENDOR_TEST, 1'b1) && CMD.data != VENDOR_TEST_LEGAL) |=> VENDOR_TEST_VIOLATION)
      else $error("vendor misuse not flagged");

   a_vendor_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
      VENDOR_TEST_VIOLATION |=> VENDOR_TEST_VIOLATION) else $error("vendor flag cleared");

   a_vendor_flag_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
      (!VENDOR_TEST_VIOLATION && !(hit(CMD, ADDR_VENDOR_TEST, 1'b1) && CMD.data != VENDOR_TEST_LEGAL))
      |=> !VENDOR_TEST_VIOLATION) else $error("vendor flag without misuse");
endmodule : mode_register_bank_mid

//--- dv/mode_ctl_model.sv
// Controller model that issues mode register commands
`timescale 1ns/1ps
module mode_ctl_model
   import mode_bank_pkg::*;
(
   input wire logic clk,
   output mode_bank_pkg::mode_cmd_t cmd
);
   initial cmd = '0;
   // One-cycle strobe launched off the falling edge, so the bank sees it settled
   task automatic issue(input logic wr, input logic rd, input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      cmd <= '{wr, rd, a, d}; // vendor register gets nonzero data only when a test asks
      @(negedge clk);
      cmd <= '0;
   endtask : issue
endmodule : mode_ctl_model

//--- dv/dram_mode_register_bank_mid_tb_top.sv
// Self-checking testbench for the mode register bank
`timescale 1ns/1ps
module dram_mode_register_bank_mid_tb_top;
   import mode_bank_pkg::*;
   localparam logic [7:0] REV_A = 8'h3C; // Arbitrary value
   localparam logic [7:0] REV_B = 8'hC3; // Arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wsel = 1'b0;
   logic osel = 1'b0;
   logic strap = 1'b0;
   logic zq = 1'b0;
   mode_cmd_t cmd;
   logic [7:0] rdata;
   logic rvalid, restore, zq_start, viol;
   logic [2:0] dq, ca;
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   mode_ctl_model ctl (.clk(clk), .cmd(cmd));
   mode_register_bank_mid #(.REV_FIRST(REV_A), .REV_SECOND(REV_B)) uut (
      .CLK(clk), .RST_N(rst_n), .CMD(cmd), .WRITE_SET_POINT_SELECT(wsel),
      .OPERATING_SET_POINT_SELECT(osel), .CAL_PIN_HAS_RESISTOR(strap), .ZQ_CAL_CMD(zq),
      .READ_DATA(rdata), .READ_VALID(rvalid), .DATA_RECEIVER_TERMINATION(dq),
      .CMD_ADDR_RECEIVER_TERMINATION(ca), .CALIBRATION_DEFAULT_RESTORE(restore),
      .ZQ_CAL_START(zq_start), .VENDOR_TEST_VIOLATION(viol));
   initial forever #5 clk = ~clk;
   task automatic results;
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e)
      begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      ctl.issue(1'b1, 1'b0, a, d);
   endtask : wr
   // Read answer stands for one cycle, so it is sampled right after the taking edge
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      ctl.issue(1'b0, 1'b1, a, 8'h00);
      chk("read_valid", 8'h01, {7'h00, rvalid});
      chk("read_data", e, rdata);
   endtask : rd
   task automatic t_ids;
      chk("read_valid", 8'h00, {7'h00, rvalid});
      chk("read_data", 8'h00, rdata);
      chk("violation", 8'h00, {7'h00, viol});
      rd(ADDR_REV_FIRST, REV_A);
      rd(ADDR_REV_SECOND, REV_B);
      rd(ADDR_GEOMETRY, {WIDTH_X16, DENSITY_16GB, TYPE_LOW_VDDQ});
      wr(ADDR_REV_FIRST, 8'hFF);
      rd(ADDR_REV_FIRST, REV_A);
      rd(ADDR_VENDOR_TEST, 8'h00);
      rd(ADDR_CAL_RESET, 8'h00);
      rd(ADDR_TERMINATION, 8'h00);
      rd(6'h3F, 8'h00);
   endtask : t_ids
   task automatic t_term;
      chk("dq", 8'h00, {5'h00, dq});
      chk("ca", 8'h00, {5'h00, ca});
      wr(ADDR_TERMINATION, 8'hDE);
      repeat (2) @(negedge clk);
      chk("dq", 8'h06, {5'h00, dq});
      chk("ca", 8'h05, {5'h00, ca});
      wsel = 1'b1;
      wr(ADDR_TERMINATION, 8'hA9);
      repeat (2) @(negedge clk);
      chk("dq", 8'h06, {5'h00, dq});
      chk("ca", 8'h05, {5'h00, ca});
      osel = 1'b1;
      @(negedge clk);
      chk("dq", 8'h01, {5'h00, dq});
      chk("ca", 8'h02, {5'h00, ca});
      // Code 7 is reserved and must show as off
      for (int k = 0; k < 8; k++)
      begin
         wr(ADDR_TERMINATION, {1'b0, k[2:0], 1'b0, k[2:0]});
         repeat (2) @(negedge clk);
         chk("dq", 8'(k % 7), {5'h00, dq});
         chk("ca", 8'(k % 7), {5'h00, ca});
      end
   endtask : t_term
   task automatic zq_pulse(input logic [7:0] e);
      @(negedge clk);
      zq = 1'b1;
      @(negedge clk);
      zq = 1'b0;
      chk("zq_start", e, {7'h00, zq_start});
   endtask : zq_pulse
   task automatic t_cal;
      wr(ADDR_CAL_RESET, 8'hFE);
      chk("restore", 8'h00, {7'h00, restore});
      wr(ADDR_CAL_RESET, 8'h01);
      chk("restore", 8'h01, {7'h00, restore});
      @(negedge clk);
      chk("restore", 8'h00, {7'h00, restore});
      zq_pulse(8'h00);
      strap = 1'b1;
      repeat (3) @(negedge clk);
      zq_pulse(8'h01);
   endtask : t_cal
   task automatic t_vendor;
      wr(ADDR_VENDOR_TEST, VENDOR_TEST_LEGAL);
      @(negedge clk);
      chk("violation", 8'h00, {7'h00, viol});
      wr(ADDR_VENDOR_TEST, 8'h5A);
      wr(ADDR_VENDOR_TEST, VENDOR_TEST_LEGAL);
      @(negedge clk);
      chk("violation", 8'h01, {7'h00, viol});
   endtask : t_vendor
   // Whole run is about 90 cycles; the ceiling leaves wide margin
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         results();
      end
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_ids();
      t_term();
      t_cal();
      t_vendor();
      results();
   end
endmodule : dram_mode_register_bank_mid_tb_top
